// ---- hdl/dtec_pkg.sv ----
// Shared constants, register map and types for the dual timer / event counter
package dtec_pkg;
    localparam int unsigned  DATA_W            = 8;
    // Register indices; byte address is four times the index
    localparam logic [5:0]   IDX_INT_CTRL      = 6'h0b;
    localparam logic [5:0]   IDX_PERIODIC_VAL  = 6'h0d;
    localparam logic [5:0]   IDX_PERIODIC_CTRL = 6'h0e;
    localparam logic [5:0]   IDX_EVENT_VAL     = 6'h10;
    localparam logic [5:0]   IDX_EVENT_CTRL    = 6'h11;
    localparam logic [5:0]   IDX_PRESCALE      = 6'h13;
    // Control register fields
    localparam int unsigned  CTRL_EDGE_BIT     = 3;
    localparam int unsigned  CTRL_RUN_BIT      = 4;
    localparam int unsigned  CTRL_MODE_LSB     = 6;
    localparam int unsigned  CTRL_MODE_MSB     = 7;
    localparam logic         CTRL_EDGE_RST     = 1'b1;
    localparam logic         CTRL_RUN_RST      = 1'b0;
    // Interrupt control flag positions
    localparam int unsigned  FLAG_PERIODIC_BIT = 5;
    localparam int unsigned  FLAG_EVENT_BIT    = 6;
    localparam int unsigned  PRESCALE_MSB      = 2;
    localparam logic [2:0]   PRESCALE_RST      = 3'h0;
    localparam logic [7:0]   COUNT_MAX         = 8'hff;
    // Instruction clock is the system clock divided by four
    localparam logic [1:0]   INSTR_LAST        = 2'h3;
    localparam logic [1:0]   RESP_OKAY         = 2'h0;
    localparam logic [1:0]   RESP_SLVERR       = 2'h2;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } dtec_mode_e;

    function automatic logic regHit(input logic [31:0] addr, input logic [5:0] idx);
        regHit = (addr == {24'h000000, idx, 2'b00});
    endfunction

    function automatic logic [7:0] ctrlWord(input dtec_mode_e mode, input logic run, input logic edgeSel);
        ctrlWord = {mode, 1'b0, run, edgeSel, 3'b000};
    endfunction
endpackage

// ---- hdl/dtec_cnt_if.sv ----
// Control and status bundle between the top and one counter
`timescale 1ns/1ps
interface dtec_cnt_if;
    logic                preloadWr;
    logic [7:0]          wrData;
    dtec_pkg::dtec_mode_e mode;
    logic                edgeSel;
    logic                run;
    logic                srcLevel;
    logic                tickEn;
    logic                hold;
    logic [7:0]          count;
    logic                overflow;
    logic                pwDone;

    modport ctl (output preloadWr, wrData, mode, edgeSel, run, srcLevel, tickEn, hold,
                 input count, overflow, pwDone);
    modport cnt (input preloadWr, wrData, mode, edgeSel, run, srcLevel, tickEn, hold,
                 output count, overflow, pwDone);
endinterface

// ---- hdl/dtec_counter8.sv ----
// One 8-bit up-counter with preload, mode select and pulse-width measurement
`timescale 1ns/1ps
module dtec_counter8 #(
    parameter bit FULL_MODES = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    dtec_cnt_if.cnt  cif
);
    logic       prevLevel;
    logic       measuring;
    logic [7:0] preload;
    logic [7:0] count;
    logic       rise;
    logic       fall;
    logic       activeEdge;
    logic       returnEdge;
    logic       inc;
    logic       wrap;
    logic       stoppedLoad;

    assign rise        = cif.srcLevel & ~prevLevel;
    assign fall        = ~cif.srcLevel & prevLevel;
    assign activeEdge  = cif.edgeSel ? fall : rise;
    assign returnEdge  = cif.edgeSel ? rise : fall;
    assign stoppedLoad = cif.preloadWr & ~cif.run;

    always_comb begin
        inc = 1'b0;
        unique case (cif.mode)
            dtec_pkg::MODE_EVENT: inc = cif.run & activeEdge;
            dtec_pkg::MODE_TIMER: inc = FULL_MODES & cif.run & cif.tickEn;
            dtec_pkg::MODE_PULSE: inc = FULL_MODES & measuring & ~returnEdge;
            dtec_pkg::MODE_OFF:   inc = 1'b0;
        endcase
        inc = inc & ~cif.hold;
    end

    assign wrap         = inc & (count == dtec_pkg::COUNT_MAX);
    assign cif.count    = count;
    assign cif.overflow = wrap;
    assign cif.pwDone   = measuring & returnEdge;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= cif.srcLevel;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            measuring <= 1'b0;
        end else if (!FULL_MODES || cif.mode != dtec_pkg::MODE_PULSE) begin
            measuring <= 1'b0;
        end else if (measuring) begin
            measuring <= ~returnEdge;
        end else begin
            measuring <= cif.run & activeEdge;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            preload <= 8'h00;
        end else if (cif.preloadWr) begin
            preload <= cif.wrData;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (stoppedLoad) begin
            count <= cif.wrData;
        end else if (wrap) begin
            count <= preload;
        end else if (inc) begin
            count <= count + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_wrap_reload;
        wrap && !stoppedLoad |=> count == $past(preload);
    endproperty
    a_wrap_reload: assert property (p_wrap_reload) else $error("no reload on overflow");

    property p_count_up;
        inc && !wrap && !stoppedLoad |=> count == 8'($past(count) + 8'h01);
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not step by one");

    property p_stopped_load;
        stoppedLoad |=> count == $past(cif.wrData);
    endproperty
    a_stopped_load: assert property (p_stopped_load) else $error("stopped write not loaded");

    property p_running_write;
        cif.preloadWr && cif.run && !inc |=> count == $past(count) && preload == $past(cif.wrData);
    endproperty
    a_running_write: assert property (p_running_write) else $error("running write disturbed count");

    property p_hold_read;
        cif.hold && !stoppedLoad |=> $stable(count);
    endproperty
    a_hold_read: assert property (p_hold_read) else $error("count moved during read");

    property p_no_full_modes;
        !FULL_MODES && cif.mode != dtec_pkg::MODE_EVENT |-> !inc && !measuring;
    endproperty
    a_no_full_modes: assert property (p_no_full_modes) else $error("periodic counter counted in bad mode");

    property p_pw_done;
        measuring && returnEdge |=> !measuring;
    endproperty
    a_pw_done: assert property (p_pw_done) else $error("measurement did not stop");

    c_wrap:    cover property (wrap);
    c_pw_done: cover property (measuring ##1 measuring ##[1:50] cif.pwDone);
    c_timer:   cover property (cif.mode == dtec_pkg::MODE_TIMER && inc);
endmodule

// ---- hdl/dtec_top.sv ----
// Dual 8-bit timer / event counter with AXI4-Lite register access
`timescale 1ns/1ps
module dtec_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        tick256In,
    input  wire logic        eventIn,
    output logic             periodicOverflowFlag,
    output logic             eventOverflowFlag
);
    dtec_cnt_if perIf();
    dtec_cnt_if evIf();

    logic                 awHave;
    logic                 wHave;
    logic [31:0]          wrAddr;
    logic [7:0]           wrByte;
    logic                 wrLane;
    logic                 doWrite;
    logic                 rdTake;
    logic                 rdMapped;
    logic [7:0]           rdByte;
    dtec_pkg::dtec_mode_e perMode;
    logic                 perRun;
    logic                 perEdge;
    dtec_pkg::dtec_mode_e evMode;
    logic                 evRun;
    logic                 evEdge;
    logic [2:0]           prescale;
    logic [1:0]           instrCnt;
    logic [6:0]           preCnt;
    logic [7:0]           preMaskWide;
    logic [6:0]           preMask;
    logic                 instrTick;
    logic                 tkSync1;
    logic                 tkSync2;
    logic                 evSync1;
    logic                 evSync2;

    assign doWrite = awHave & wHave & ~s_axi_bvalid;
    assign rdTake  = s_axi_arready & s_axi_arvalid;

    // Write address and data are taken independently, in either order
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            awHave        <= 1'b0;
            wrAddr        <= 32'h00000000;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            awHave        <= 1'b1;
            wrAddr        <= s_axi_awaddr;
        end else if (doWrite) begin
            awHave        <= 1'b0;
        end else if (!awHave && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b0;
            wHave        <= 1'b0;
            wrByte       <= 8'h00;
            wrLane       <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            wHave        <= 1'b1;
            wrByte       <= s_axi_wdata[7:0];
            wrLane       <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHave        <= 1'b0;
        end else if (!wHave && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dtec_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_INT_CTRL)
                          || dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_PERIODIC_VAL)
                          || dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_PERIODIC_CTRL)
                          || dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_EVENT_VAL)
                          || dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_EVENT_CTRL)
                          || dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_PRESCALE))
                          ? dtec_pkg::RESP_OKAY : dtec_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rdMapped = 1'b1;
        unique case (1'b1)
            dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_PERIODIC_VAL):  rdByte = perIf.count;
            dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_PERIODIC_CTRL): rdByte = dtec_pkg::ctrlWord(perMode, perRun, perEdge);
            dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_EVENT_VAL):     rdByte = evIf.count;
            dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_EVENT_CTRL):    rdByte = dtec_pkg::ctrlWord(evMode, evRun, evEdge);
            dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_INT_CTRL):      rdByte = {1'b0, eventOverflowFlag,
                                                                             periodicOverflowFlag, 5'h00};
            dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_PRESCALE):      rdByte = {5'h00, prescale};
            default: begin
                rdByte   = 8'h00;
                rdMapped = 1'b0;
            end
        endcase
    end

    // value reads return the live count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= dtec_pkg::RESP_OKAY;
        end else if (rdTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rdByte};
            s_axi_rresp   <= rdMapped ? dtec_pkg::RESP_OKAY : dtec_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid  <= ~s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            perMode <= dtec_pkg::MODE_OFF;
            perRun  <= dtec_pkg::CTRL_RUN_RST;
            perEdge <= dtec_pkg::CTRL_EDGE_RST;
        end else if (doWrite && wrLane && dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_PERIODIC_CTRL)) begin
            perMode <= dtec_pkg::dtec_mode_e'(wrByte[dtec_pkg::CTRL_MODE_MSB:dtec_pkg::CTRL_MODE_LSB]);
            perRun  <= wrByte[dtec_pkg::CTRL_RUN_BIT];
            perEdge <= wrByte[dtec_pkg::CTRL_EDGE_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evMode <= dtec_pkg::MODE_OFF;
            evRun  <= dtec_pkg::CTRL_RUN_RST;
            evEdge <= dtec_pkg::CTRL_EDGE_RST;
        end else if (doWrite && wrLane && dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_EVENT_CTRL)) begin
            evMode <= dtec_pkg::dtec_mode_e'(wrByte[dtec_pkg::CTRL_MODE_MSB:dtec_pkg::CTRL_MODE_LSB]);
            evRun  <= wrByte[dtec_pkg::CTRL_RUN_BIT];
            evEdge <= wrByte[dtec_pkg::CTRL_EDGE_BIT];
        end else if (evIf.pwDone) begin
            evRun  <= 1'b0;
        end
    end

    // sticky flags, set beats a software clear; any mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            periodicOverflowFlag <= 1'b0;
            eventOverflowFlag    <= 1'b0;
        end else if (doWrite && wrLane && dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_INT_CTRL)) begin
            periodicOverflowFlag <= (periodicOverflowFlag & wrByte[dtec_pkg::FLAG_PERIODIC_BIT]) | perIf.overflow;
            eventOverflowFlag    <= (eventOverflowFlag & wrByte[dtec_pkg::FLAG_EVENT_BIT]) | evIf.overflow;
        end else begin
            periodicOverflowFlag <= periodicOverflowFlag | perIf.overflow;
            eventOverflowFlag    <= eventOverflowFlag | evIf.overflow;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= dtec_pkg::PRESCALE_RST;
        end else if (doWrite && wrLane && dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_PRESCALE)) begin
            prescale <= wrByte[dtec_pkg::PRESCALE_MSB:0];
        end
    end

    // instruction clock is system clock over four
    assign instrTick   = (instrCnt == dtec_pkg::INSTR_LAST);
    assign preMaskWide = (8'h01 << prescale) - 8'h01;
    assign preMask     = preMaskWide[6:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instrCnt <= 2'h0;
            preCnt   <= 7'h00;
        end else begin
            instrCnt <= instrCnt + 2'h1;
            if (instrTick) begin
                preCnt <= preCnt + 7'h01;
            end
        end
    end

    // two-stage synchronisers ahead of edge detection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tkSync1 <= 1'b0;
            tkSync2 <= 1'b0;
            evSync1 <= 1'b0;
            evSync2 <= 1'b0;
        end else begin
            tkSync1 <= tick256In;
            tkSync2 <= tkSync1;
            evSync1 <= eventIn;
            evSync2 <= evSync1;
        end
    end

    // Value writes go to preload; the counter decides whether to load now
    assign perIf.preloadWr = doWrite & wrLane & dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_PERIODIC_VAL);
    assign perIf.wrData    = wrByte;
    assign perIf.mode      = perMode;
    assign perIf.edgeSel   = perEdge;
    assign perIf.run       = perRun;
    assign perIf.srcLevel  = tkSync2;
    assign perIf.tickEn    = 1'b0;
    // a value read stalls that counter for the capture cycle
    assign perIf.hold      = rdTake & dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_PERIODIC_VAL);

    assign evIf.preloadWr  = doWrite & wrLane & dtec_pkg::regHit(wrAddr, dtec_pkg::IDX_EVENT_VAL);
    assign evIf.wrData     = wrByte;
    assign evIf.mode       = evMode;
    assign evIf.edgeSel    = evEdge;
    assign evIf.run        = evRun;
    assign evIf.srcLevel   = evSync2;
    assign evIf.tickEn     = instrTick & ((preCnt & preMask) == preMask);
    assign evIf.hold       = rdTake & dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_EVENT_VAL);

    // Periodic counter lacks timer and pulse-width modes
    dtec_counter8 #(
        .FULL_MODES (1'b0)
    ) u_periodic (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cif     (perIf.cnt)
    );

    dtec_counter8 #(
        .FULL_MODES (1'b1)
    ) u_event (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cif     (evIf.cnt)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_flag_set;
        evIf.overflow |=> eventOverflowFlag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag not set");

    property p_run_clear;
        evIf.pwDone && !doWrite |=> !evRun;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("run not cleared after measurement");

    property p_ctrl_zero;
        rdTake && dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_EVENT_CTRL)
            |=> s_axi_rvalid && s_axi_rdata[2:0] == 3'h0 && !s_axi_rdata[5];
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused control bits not zero");

    property p_write_resp;
        doWrite |=> s_axi_bvalid ##0 !awHave ##0 !wHave;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write not answered");

    c_rd_value: cover property (rdTake && dtec_pkg::regHit(s_axi_araddr, dtec_pkg::IDX_EVENT_VAL));
    c_per_flag: cover property ($rose(periodicOverflowFlag));
endmodule

// ---- sim/dtec_event_src.sv ----
// Behavioural source of the external event pin and the 256 Hz tick
`timescale 1ns/1ps
module dtec_event_src (
    input wire logic ref_clk,
    output logic     eventIn,
    output logic     tick256In
);
    initial begin
        eventIn = 1'b0;
        tick256In = 1'b0;
    end

    task automatic pulse(input bit tick, input int n);
        begin
            @(posedge ref_clk);
            {tick256In, eventIn} <= tick ? 2'b10 : 2'b01;
            repeat (n) @(posedge ref_clk);
            {tick256In, eventIn} <= 2'b00;
            repeat (n) @(posedge ref_clk);
        end
    endtask
endmodule

// ---- sim/dual_timer_event_counter_test.sv ----
// Register-level test of the dual timer / event counter
`timescale 1ns/1ps
module dual_timer_event_counter_test;
    logic        ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        eventIn, tick256In, periodicOverflowFlag, eventOverflowFlag;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
    int          fails, nTests, cyc;

    dtec_top dut (.*);
    dtec_event_src src (.*);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic conclude;
        if (fails == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        nTests++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (1) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                br = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit c = 1'b1);
        @(posedge ref_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (1) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (c) chk(rv, {24'h0, e});
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        {fails, nTests, cyc} = '0;
        rst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h38, 8'h08);
        rd(8'h44, 8'h08);
        rd(8'h40, 8'h00);
        rd(8'h50, 8'h00);
        chk({30'h0, rr}, 32'h2);
        wr(8'h50, 8'h11);
        chk({30'h0, br}, 32'h2);
        wr(8'h44, 8'hef);
        chk({30'h0, br}, 32'h0);
        rd(8'h44, 8'hc8);
        wr(8'h40, 8'hfd);
        rd(8'h40, 8'hfd);
        wr(8'h44, 8'h50);
        src.pulse(1'b0, 4);
        src.pulse(1'b0, 4);
        rd(8'h40, 8'hff);
        wr(8'h40, 8'h10);
        rd(8'h40, 8'hff);
        src.pulse(1'b0, 4);
        rd(8'h40, 8'h10);
        chk({31'h0, eventOverflowFlag}, 32'h1);
        rd(8'h2c, 8'h40);
        rd(8'h44, 8'h50);
        wr(8'h2c, 8'h00);
        chk({31'h0, eventOverflowFlag}, 32'h0);
        wr(8'h44, 8'h58);
        src.pulse(1'b0, 4);
        rd(8'h40, 8'h11);
        wr(8'h44, 8'h48);
        src.pulse(1'b0, 4);
        rd(8'h40, 8'h11);
        wr(8'h38, 8'h90);
        src.pulse(1'b1, 4);
        rd(8'h34, 8'h00);
        wr(8'h38, 8'h50);
        src.pulse(1'b1, 4);
        rd(8'h34, 8'h01);
        wr(8'h38, 8'h40);
        wr(8'h34, 8'hff);
        rd(8'h34, 8'hff);
        wr(8'h38, 8'h50);
        src.pulse(1'b1, 4);
        chk({31'h0, periodicOverflowFlag}, 32'h1);
        rd(8'h34, 8'hff);
        rd(8'h2c, 8'h20);
        wr(8'h40, 8'h00);
        wr(8'h4c, 8'h00);
        wr(8'h44, 8'h90);
        repeat (40) @(posedge ref_clk);
        wr(8'h44, 8'h80);
        // Run bit stands for 44 clocks, which hold exactly eleven instruction ticks
        rd(8'h40, 8'h0b);
        wr(8'h40, 8'h00);
        wr(8'h44, 8'hd0);
        src.pulse(1'b0, 20);
        rd(8'h44, 8'hc0);
        rd(8'h40, 8'h00, 1'b0);
        chk({31'h0, rv inside {[18:22]}}, 32'h1);
        conclude();
    end
endmodule
